// file: inc/defrost_pkg.sv
package defrost_pkg;

	// Timing base for the interval counter.
	localparam int unsigned SYS_CLK_HZ      = 50000000;
	localparam int unsigned TICK_HZ_X100    = 9375000;
	localparam int unsigned HYST_SECONDS    = 10;
	localparam int unsigned DEFROST_MINUTES = 30;
	localparam int unsigned SEC_PER_MIN     = 60;
	localparam int unsigned TICK_CLK_HZ     = TICK_HZ_X100 / 100;

	// Tick prescaler: 50 MHz / 93.75 kHz is 533.33 cycles.
	localparam logic [31:0] TICK_NUM        = 32'h00000003;
	localparam logic [31:0] TICK_DEN        = 32'h00000640;

	// Interval lengths in ticks of the interval counter.
	localparam logic [31:0] HYST_TICKS      =
		32'(HYST_SECONDS * TICK_CLK_HZ);
	localparam logic [31:0] DEFROST_TICKS   =
		32'(DEFROST_MINUTES * SEC_PER_MIN * TICK_CLK_HZ);

	// Bit positions within the output port data.
	localparam int unsigned HEATER_BIT      = 4;
	localparam int unsigned FAN_BIT         = 5;
	localparam int unsigned ACT_BIT         = 7;
	localparam int unsigned AIR_BIT         = 2;
	localparam logic [7:0]  PORT_RESET      = 8'ha0;

	// Sequencer states.
	typedef enum logic [2:0] {
		ST_SETTLE  = 3'h0,
		ST_WAITLOW = 3'h1,
		ST_CONFIRM = 3'h2,
		ST_DEFROST = 3'h3,
		ST_HALT    = 3'h4
	} seq_state_e;

endpackage

// file: verilog/interval_counter.sv
`timescale 1ns/1ps
// Fractional prescaler producing the 93.75 kHz tick and a 32-bit down
// counter loaded on start; done pulses one cycle when it reaches zero.
module interval_counter #(
	parameter logic [31:0] TICK_NUM = defrost_pkg::TICK_NUM,
	parameter logic [31:0] TICK_DEN = defrost_pkg::TICK_DEN
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        start,
	input  wire logic [31:0] period,
	output logic             done,
	output logic             tick
);
	typedef struct packed {
		logic [31:0] acc;
		logic [31:0] count;
		logic        running;
		logic        done;
		logic        tick;
	} cnt_s;

	cnt_s cnt_reg;
	cnt_s cnt_next;

	// Accumulator keeps the long-run tick rate exact without a PLL.
	always_comb begin
		cnt_next = cnt_reg;
		cnt_next.done = 1'b0;
		cnt_next.tick = 1'b0;
		if (cnt_reg.acc + TICK_NUM >= TICK_DEN) begin
			cnt_next.acc = cnt_reg.acc + TICK_NUM - TICK_DEN;
			cnt_next.tick = 1'b1;
		end else begin
			cnt_next.acc = cnt_reg.acc + TICK_NUM;
		end
		if (start) begin
			cnt_next.count = period;
			cnt_next.running = 1'b1;
		end else if (cnt_reg.running && cnt_reg.tick) begin
			if (cnt_reg.count <= 32'h00000001) begin
				cnt_next.count = 32'h00000000;
				cnt_next.running = 1'b0;
				cnt_next.done = 1'b1;
			end else begin
				cnt_next.count = cnt_reg.count - 32'h00000001;
			end
		end
	end

	// State register.
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	assign done = cnt_reg.done;
	assign tick = cnt_reg.tick;
endmodule // interval_counter

// file: verilog/defrost_cycle_sequencer.sv
`timescale 1ns/1ps
// Function
// - Defrost starts only after input stays low beyond ten-second hysteresis.
// - Airflow indicator follows the switch input level.
// - Heater and its indicator on exactly while defrosting.
// - Fan and its indicator on whenever not defrosting or halted.
// - Actuator behaves identically to fan.
// - Timing uses 32-bit counter advanced by 93.75 kHz tick.
// - Defrost defaults to thirty minutes; both intervals are build parameters.
// - Build option selects repeat or halt after first defrost.
// - Short low pulse leaves heater, fan and actuator unchanged.
// - Reset and each pass start: fan and actuator on, heater off.
// - Repeating build returns to idle outputs and resumes monitoring.
// - Non-repeating build drops all relays and halts after defrost.
// - Port bits: heater 0x10, fan 0x20, actuator 0x80, input mask 4.
module defrost_cycle_sequencer #(
	// Both intervals are build-time; defrost defaults to thirty minutes.
	parameter logic [31:0] HYST_TICKS    = defrost_pkg::HYST_TICKS,
	parameter logic [31:0] DEFROST_TICKS = defrost_pkg::DEFROST_TICKS,
	parameter bit          LOOP          = 1'b1
) (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       switchIn,
	output logic            heaterRelay,
	output logic            fanRelay,
	output logic            actRelay,
	output logic            heaterLed,
	output logic            fanLed,
	output logic            actLed,
	output logic            airLed,
	output logic            halted,
	output logic [7:0]      outputPortData
);
	typedef struct packed {
		logic                   sync1;
		logic                   sync2;
		defrost_pkg::seq_state_e state;
		logic                   start;
		logic [31:0]            period;
		logic [7:0]             port;
		logic                   air;
	} seq_s;

	seq_s seq_reg;
	seq_s seq_next;
	logic timerDone;

	interval_counter #(
		.TICK_NUM (defrost_pkg::TICK_NUM),
		.TICK_DEN (defrost_pkg::TICK_DEN)
	) timerInst (
		.clk    (clk),
		.rst    (rst),
		.start  (seq_reg.start),
		.period (seq_reg.period),
		.done   (timerDone),
		.tick   ()
	);

	// Drive pattern for the relay byte; one place keeps the bits consistent.
	function automatic logic [7:0] relayByte(input logic heat,
		input logic cool);
		logic [7:0] b;
		b = 8'h00;
		b[defrost_pkg::HEATER_BIT] = heat;
		b[defrost_pkg::FAN_BIT] = cool;
		b[defrost_pkg::ACT_BIT] = cool;
		return b;
	endfunction

	// A new monitoring pass re-arms the first interval with idle relays.
	function automatic seq_s beginPass(input seq_s s);
		seq_s r;
		r = s;
		r.state = defrost_pkg::ST_SETTLE;
		r.start = 1'b1;
		r.period = HYST_TICKS;
		r.port = relayByte(1'b0, 1'b1);
		return r;
	endfunction

	// Sequencer. The switch is a pin, so only the second stage is read.
	always_comb begin
		seq_next = seq_reg;
		seq_next.sync1 = switchIn;
		seq_next.sync2 = seq_reg.sync1;
		seq_next.start = 1'b0;
		seq_next.air = seq_reg.sync2;
		case (seq_reg.state)
			defrost_pkg::ST_SETTLE: begin
				// Low watch after the first interval.
				if (timerDone) begin
					seq_next.state = defrost_pkg::ST_WAITLOW;
				end
			end
			defrost_pkg::ST_WAITLOW: begin
				if (!seq_reg.sync2) begin
					seq_next.state = defrost_pkg::ST_CONFIRM;
					seq_next.start = 1'b1;
					seq_next.period = HYST_TICKS;
				end
			end
			defrost_pkg::ST_CONFIRM: begin
				if (seq_reg.sync2) begin
					// Low run broken: relays stay idle, new pass.
					seq_next = beginPass(seq_next);
				end else if (timerDone) begin
					// Low held through the whole interval.
					seq_next.state = defrost_pkg::ST_DEFROST;
					seq_next.start = 1'b1;
					seq_next.period = DEFROST_TICKS;
					// Heater on, fan and actuator off.
					seq_next.port = relayByte(1'b1, 1'b0);
				end
			end
			defrost_pkg::ST_DEFROST: begin
				if (timerDone) begin
					if (LOOP) begin
						seq_next = beginPass(seq_next);
					end else begin
						seq_next.state = defrost_pkg::ST_HALT;
						seq_next.port = relayByte(1'b0, 1'b0);
					end
				end
			end
			defrost_pkg::ST_HALT: begin
				seq_next.port = 8'h00;
			end
			default: begin
				seq_next.state = defrost_pkg::ST_HALT;
				seq_next.port = 8'h00;
			end
		endcase
	end

	// Reset leaves fan and actuator on and arms the first interval.
	always_ff @(posedge clk) begin
		if (rst) begin
			seq_reg.sync1 <= 1'b0;
			seq_reg.sync2 <= 1'b0;
			seq_reg.state <= defrost_pkg::ST_SETTLE;
			seq_reg.start <= 1'b1;
			seq_reg.period <= HYST_TICKS;
			seq_reg.port <= defrost_pkg::PORT_RESET;
			seq_reg.air <= 1'b0;
		end else begin
			seq_reg <= seq_next;
		end
	end

	// Relays and indicators from one registered byte.
	assign heaterRelay = seq_reg.port[defrost_pkg::HEATER_BIT];
	assign fanRelay = seq_reg.port[defrost_pkg::FAN_BIT];
	assign actRelay = seq_reg.port[defrost_pkg::ACT_BIT];
	assign heaterLed = seq_reg.port[defrost_pkg::HEATER_BIT];
	assign fanLed = seq_reg.port[defrost_pkg::FAN_BIT];
	assign actLed = seq_reg.port[defrost_pkg::ACT_BIT];
	// Input sits at mask 4 in the port readback.
	always_comb begin
		outputPortData = seq_reg.port;
		outputPortData[defrost_pkg::AIR_BIT] = seq_reg.air;
	end
	assign airLed = seq_reg.air;
	assign halted = (seq_reg.state == defrost_pkg::ST_HALT);
endmodule // defrost_cycle_sequencer

// file: testbench/pressure_switch.sv
`timescale 1ns/1ps
// Differential switch: contacts open, line low, when the coil clogs.
module pressure_switch (
	input  wire logic clogged,
	output wire logic switchIn
);
	// No bounce modelled; the sequencer's hysteresis is tested instead.
	assign switchIn = !clogged;
endmodule // pressure_switch

// file: testbench/defrost_sva.sv
`timescale 1ns/1ps
// Pin-level watch over relays, port image and defrost length.
module defrost_sva #(
	parameter logic [31:0] HYST_TICKS    = 32'h4,
	parameter logic [31:0] DEFROST_TICKS = 32'h8,
	parameter bit          LOOP          = 1'b1
) (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       switchIn,
	input wire logic       heaterRelay,
	input wire logic       fanRelay,
	input wire logic       actRelay,
	input wire logic       airLed,
	input wire logic       halted,
	input wire logic [7:0] outputPortData
);
	localparam int unsigned DCLK = DEFROST_TICKS * 1600 / 3;
	// A tick may land just after the load, so intervals run one tick short.
	localparam int unsigned DMIN = (DEFROST_TICKS - 1) * 1600 / 3;
	localparam int unsigned HMIN = (HYST_TICKS - 1) * 1600 / 3;
	logic [31:0] heatCnt;
	logic [31:0] lowCnt;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Clocks with the heater on, and with the airflow indicator dark.
	always_ff @(posedge clk) begin
		heatCnt <= (rst || !heaterRelay) ? 32'h0 : heatCnt + 32'h1;
		lowCnt <= (rst || airLed) ? 32'h0 : lowCnt + 32'h1;
	end
	chk_heat_excl: assert property (heaterRelay |-> !fanRelay)
		else $error("heater and fan on");
	chk_fan_act: assert property (fanRelay == actRelay)
		else $error("fan and actuator differ");
	chk_port_map: assert property (outputPortData == {actRelay, 1'b0,
		fanRelay, heaterRelay, 1'b0, airLed, 2'h0}) else $error("port image");
	chk_reset_idle: assert property ($fell(rst) |-> fanRelay &&
		!heaterRelay && !halted) else $error("not idle after reset");
	chk_defrost_len: assert property ($fell(heaterRelay) |->
		heatCnt >= DMIN && heatCnt <= DCLK + 8) else $error("length");
	chk_air_follow: assert property (!$past(rst, 3) && !$past(rst, 2)
		&& !$past(rst) |-> airLed == $past(switchIn, 3))
		else $error("airflow indicator lags the switch");
	chk_low_run: assert property ($rose(heaterRelay) |->
		lowCnt >= HMIN) else $error("defrost without a full low run");
	chk_halt_dark: assert property (halted |-> !fanRelay && !heaterRelay)
		else $error("relay on while halted");
	chk_halt_keep: assert property (halted |=> halted)
		else $error("halt left");
	chk_loop_back: assert property ($fell(heaterRelay) |->
		(LOOP ? fanRelay && !halted : halted)) else $error("after defrost");
endmodule // defrost_sva

bind defrost_cycle_sequencer defrost_sva #(.HYST_TICKS(HYST_TICKS),
	.DEFROST_TICKS(DEFROST_TICKS), .LOOP(LOOP)) sva (.clk(clk), .rst(rst),
	.switchIn(switchIn), .heaterRelay(heaterRelay),
	.fanRelay(fanRelay), .actRelay(actRelay), .airLed(airLed),
	.halted(halted), .outputPortData(outputPortData));

// file: testbench/defrost_cycle_sequencer_tb.sv
`timescale 1ns/1ps
// One switch feeds both builds: DUT repeats, DUT2 halts.
module defrost_cycle_sequencer_tb;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic       clog = 1'b0;
	logic       prev = 1'b0;
	logic       sw, heat, fan, act, air, halt, heat2, fan2, act2, halt2;
	logic       hLed, fLed, aLed;
	logic [7:0] port;
	logic [1:0] noteQ[$];
	integer     errCount = 0;
	integer     testsRun = 0;
	integer     cyc = 0;
	integer     seed = 32'hee4453b6;
	integer     n;
	pressure_switch PS (.clogged(clog), .switchIn(sw));
	defrost_cycle_sequencer #(.HYST_TICKS(32'h4), .DEFROST_TICKS(32'h8),
		.LOOP(1'b1)) DUT (.clk(clk), .rst(rst), .switchIn(sw),
		.heaterRelay(heat), .fanRelay(fan), .actRelay(act), .heaterLed(hLed),
		.fanLed(fLed), .actLed(aLed), .airLed(air), .halted(halt),
		.outputPortData(port));
	defrost_cycle_sequencer #(.HYST_TICKS(32'h4), .DEFROST_TICKS(32'h8),
		.LOOP(1'b0)) DUT2 (.clk(clk), .rst(rst), .switchIn(sw),
		.heaterRelay(heat2), .fanRelay(fan2), .actRelay(act2), .heaterLed(),
		.fanLed(), .actLed(), .airLed(), .halted(halt2), .outputPortData());
	always #10 clk = ~clk;
	task automatic cmp(input string s, input logic [3:0] x, input logic [3:0] g);
		testsRun++;
		if (g !== x) begin
			errCount++;
			$display("BAD %s exp %h got %h", s, x, g);
		end
	endtask
	task automatic waitHeat(input logic v);
		for (n = 0; n < 9000 && heat !== v; n++) @(negedge clk);
	endtask
	task closeOut;
		$display("checks %0d mismatches %0d", testsRun, errCount);
		if (errCount == 0 && testsRun > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Hang guard; the sequence needs about 21000 cycles.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			errCount++;
			closeOut;
		end
	end
	// Each heater edge takes the oldest note; a stray edge finds none.
	always @(negedge clk) begin
		if (!rst && heat !== prev) begin
			cmp("relays", {2'h0, noteQ.size() ? noteQ.pop_front() : 2'bxx},
				{2'h0, heat, fan});
		end
		prev <= heat;
	end
	// Reset, a short low pulse, a full defrost, then a second pass.
	initial begin
		repeat (16) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		cmp("idle", 4'h6, {heat, fan, act, halt});
		cmp("ledidle", 4'h3, {1'b0, hLed, fLed, aLed});
		cmp("portidle", 4'ha, port[7:4]);
		repeat (3000) @(negedge clk);
		clog = 1'b1;
		repeat (200 + ($random(seed) & 32'h3ff)) @(negedge clk);
		cmp("airlow", 4'h0, {3'h0, air});
		clog = 1'b0;
		repeat (6000) @(negedge clk);
		cmp("pulse", 4'hb, {air, heat, fan, act});
		cmp("portair", 4'h4, port[3:0]);
		$display("pulse test done");
		noteQ.push_back(2'b10);
		clog = 1'b1;
		waitHeat(1'b1);
		// Tick phase may trim up to one tick off the interval.
		cmp("lowtime", 4'h1, {3'h0, n > 1600});
		cmp("defrost", 4'h9, {heat, fan, act, heat2});
		cmp("ledheat", 4'h4, {1'b0, hLed, fLed, aLed});
		cmp("portheat", 4'h1, port[7:4]);
		noteQ.push_back(2'b01);
		clog = 1'b0;
		waitHeat(1'b0);
		// Eight ticks span seven whole tick gaps plus the load phase.
		cmp("length", 4'h1, {3'h0, n > 3732 && n < 4275});
		cmp("loop", 4'h6, {heat, fan, act, halt});
		cmp("ledloop", 4'h3, {1'b0, hLed, fLed, aLed});
		cmp("halt", 4'h1, {heat2, fan2, act2, halt2});
		$display("defrost test done");
		noteQ.push_back(2'b10);
		clog = 1'b1;
		waitHeat(1'b1);
		cmp("again", 4'h9, {heat, fan, act, halt2});
		$display("repeat test done");
		closeOut;
	end
endmodule // defrost_cycle_sequencer_tb
